// ### ldc_ctrl.sv
// Purpose: write-only two-wire target and current/mode control register
// Assumes: SCL and SDA come from pins and are synchronised to MCLK here
// Notes:   SDA is open drain; the enable is low while the target pulls low
// What this block does
// - answer only address 1001111 with write bit
// - drive the data line only for acknowledge
// - bits seven and six reserved, used only in the register-zero test
// - bit five high: indicator mode, fixed sink two
// - bit five low: both sinks follow setting
// - current bits only matter in normal mode
// - bits four to zero binary weighted current
// - current latched on eighth clock of byte
// - register zero: pump off, sinks disconnected
// - indicator mode: pump off, sink one detached
// - overvoltage halts pump, no latching
module ldc_ctrl
  import ldc_pkg::*;
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST,
  // two-wire bus pins
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N,
  // analog guard
  input  wire logic       OVERVOLTAGE_GUARD,
  // drive to the analog side
  output logic            PUMP_ON,
  output logic            FIRST_CURRENT_SINK_ON,
  output logic            SECOND_CURRENT_SINK_ON,
  output logic            INDICATOR_MODE_SELECT,
  output logic [4:0]      REFERENCE_CURRENT,
  output logic [7:0]      LED_CURRENT_AND_MODE_CONTROL
);
  // two-flop synchronisers for pins
  logic [1:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d, ovp_s_q, ovp_s_d;
  logic       scl_o_q, scl_o_d, sda_o_q, sda_o_d;
  logic       scl_rise, scl_fall, start_c, stop_c;

  always_comb
  begin
    scl_s_d = {scl_s_q[0], SCL_IN};
    sda_s_d = {sda_s_q[0], SDA_IN};
    ovp_s_d = {ovp_s_q[0], OVERVOLTAGE_GUARD};
    scl_o_d = scl_s_q[1];
    sda_o_d = sda_s_q[1];
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      ovp_s_q <= 2'h0;
      scl_o_q <= 1'b1;
      sda_o_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      ovp_s_q <= ovp_s_d;
      scl_o_q <= scl_o_d;
      sda_o_q <= sda_o_d;
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_o_q;
  assign scl_fall = ~scl_s_q[1] & scl_o_q;
  assign start_c  = scl_s_q[1] & scl_o_q & sda_o_q & ~sda_s_q[1];
  assign stop_c   = scl_s_q[1] & scl_o_q & ~sda_o_q & sda_s_q[1];

  // frame receiver
  ldc_state_t state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic       ack_q, ack_d;
  logic       reg_ok_q, reg_ok_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] next_byte;

  assign next_byte = {shift_q[6:0], sda_s_q[1]};

  always_comb
  begin
    state_d  = state_q;
    shift_d  = shift_q;
    bit_d    = bit_q;
    byte_d   = byte_q;
    ack_d    = ack_q;
    reg_ok_d = reg_ok_q;
    ctrl_d   = ctrl_q;
    if (start_c)
    begin
      state_d  = ST_RECV;
      bit_d    = 4'h0;
      byte_d   = 2'h0;
      ack_d    = 1'b0;
      reg_ok_d = 1'b0;
    end
    else if (stop_c)
    begin
      state_d = ST_IDLE;
      ack_d   = 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          ack_d = 1'b0;
        end
        ST_RECV:
        begin
          if (scl_rise)
          begin
            shift_d = next_byte;
            bit_d   = bit_q + 4'h1;
            if (bit_q == LDC_BITS_PER_BYTE - 4'h1)
            begin
              // decision on the eighth rising edge of the byte
              case (byte_q)
                2'h0: ack_d = (next_byte == LDC_WRITE_ADDR);
                2'h1:
                begin
                  ack_d    = 1'b1;
                  reg_ok_d = (next_byte == LDC_CTRL_OFFSET);
                end
                2'h2:
                begin
                  ack_d = 1'b1;
                  // latched on the eighth clock, a wrong offset is not stored
                  if (reg_ok_q)
                  begin
                    ctrl_d = next_byte;
                  end
                end
                default: ack_d = 1'b0; // extra bytes beyond three are refused
              endcase
            end
          end
          else if (scl_fall && bit_q == LDC_BITS_PER_BYTE)
          begin
            state_d = ack_q ? ST_ACK : ST_SKIP;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            // release after the ninth clock
            ack_d   = 1'b0;
            bit_d   = 4'h0;
            byte_d  = (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
            state_d = ST_RECV;
          end
        end
        ST_SKIP:
        begin
          ack_d = 1'b0;
        end
        default:
        begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_q  <= ST_IDLE;
      shift_q  <= 8'h00;
      bit_q    <= 4'h0;
      byte_q   <= 2'h0;
      ack_q    <= 1'b0;
      reg_ok_q <= 1'b0;
      ctrl_q   <= LDC_CTRL_RESET;
    end
    else
    begin
      state_q  <= state_d;
      shift_q  <= shift_d;
      bit_q    <= bit_d;
      byte_q   <= byte_d;
      ack_q    <= ack_d;
      reg_ok_q <= reg_ok_d;
      ctrl_q   <= ctrl_d;
    end
  end

  // drive decode; reserved bits are stored and only take part in the all-zero test
  ldc_drive_t drv_d, drv_q;
  logic       sda_oe_n_d, sda_oe_n_q;

  always_comb
  begin
    drv_d.indicator = ctrl_q[LDC_MODE_BIT];
    drv_d.current   = ctrl_q[LDC_CUR_MSB:0];
    if (ctrl_q == 8'h00)
    begin
      drv_d.pump_on  = 1'b0;
      drv_d.sink1_on = 1'b0;
      drv_d.sink2_on = 1'b0;
    end
    else if (ctrl_q[LDC_MODE_BIT])
    begin
      // indicator current is fixed in the analog side, setting is ignored
      drv_d.pump_on  = 1'b0;
      drv_d.sink1_on = 1'b0;
      drv_d.sink2_on = 1'b1;
    end
    else
    begin
      drv_d.pump_on  = ~ovp_s_q[1];
      drv_d.sink1_on = 1'b1;
      drv_d.sink2_on = 1'b1;
    end
    // only an acknowledge ever pulls the line; enable kept in its own flop, no gate to the pin
    sda_oe_n_d = !((state_q == ST_ACK) && ack_q && !start_c && !stop_c);
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      drv_q      <= '0;
      sda_oe_n_q <= 1'b1;
    end
    else
    begin
      drv_q      <= drv_d;
      sda_oe_n_q <= sda_oe_n_d;
    end
  end

  assign SDA_OUT                      = 1'b0;
  assign SDA_OE_N                     = sda_oe_n_q;
  assign PUMP_ON                      = drv_q.pump_on;
  assign FIRST_CURRENT_SINK_ON        = drv_q.sink1_on;
  assign SECOND_CURRENT_SINK_ON       = drv_q.sink2_on;
  assign INDICATOR_MODE_SELECT        = drv_q.indicator;
  assign REFERENCE_CURRENT            = drv_q.current;
  assign LED_CURRENT_AND_MODE_CONTROL = ctrl_q;
endmodule : ldc_ctrl

// ### ldc_pkg.sv
// Purpose: shared constants and types for the backlight two-wire control block
// Assumes: one system clock MCLK at 200 MHz, bus pins sampled through two flops
// Notes:   the control register holds reserved, mode and current fields
package ldc_pkg;
  localparam logic [6:0] LDC_TARGET_ADDR   = 7'h4f;
  localparam logic [7:0] LDC_WRITE_ADDR    = 8'h9e;
  localparam logic [7:0] LDC_CTRL_OFFSET   = 8'h01;
  localparam logic [7:0] LDC_CTRL_RESET    = 8'h00;
  localparam int         LDC_MODE_BIT      = 5;
  localparam int         LDC_CUR_MSB       = 4;
  localparam int         LDC_RSV_LSB       = 6;
  localparam logic [4:0] LDC_CUR_MAX       = 5'h1e;
  localparam int         LDC_IND_UA        = 450;
  localparam logic [3:0] LDC_BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b010,
    ST_SKIP = 3'b011
  } ldc_state_t;

  // what the analog side is told to do
  typedef struct packed
  {
    logic       pump_on;
    logic       sink1_on;
    logic       sink2_on;
    logic       indicator;
    logic [4:0] current;
  } ldc_drive_t;
endpackage : ldc_pkg

// ### ldc_ctrl_properties.sv
// Purpose: port checks for ldc_ctrl
// Assumes: slow bus clock
// Notes: bind at the foot
module ldc_ctrl_properties
  import ldc_pkg::*;
(
  // clock
  input logic       MCLK,
  input logic       RST,
  // pins
  input logic       SCL_IN,
  input logic       SDA_OE_N,
  input logic       OVERVOLTAGE_GUARD,
  input logic       PUMP_ON,
  input logic       FIRST_CURRENT_SINK_ON,
  input logic       SECOND_CURRENT_SINK_ON,
  input logic [4:0] REFERENCE_CURRENT,
  input logic [7:0] LED_CURRENT_AND_MODE_CONTROL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire [7:0] c   = LED_CURRENT_AND_MODE_CONTROL;
  wire       p   = PUMP_ON;
  wire       s1  = FIRST_CURRENT_SINK_ON;
  wire       s2  = SECOND_CURRENT_SINK_ON;
  wire       nrm = c != 8'h00 && !c[LDC_MODE_BIT];
  sequence s_ack; $fell(SDA_OE_N); endsequence
  property p_off; c == 8'h00 |=> !p && !s1 && !s2; endproperty
  property p_ind; c[LDC_MODE_BIT] |=> !p && !s1 && s2; endproperty
  property p_nrm; nrm |=> s1 && s2; endproperty
  property p_cur; $stable(c) [*2] |-> REFERENCE_CURRENT == c[4:0]; endproperty
  property p_ack; s_ack |-> !SCL_IN; endproperty
  property p_hold; s_ack |-> !SDA_OE_N [*8]; endproperty
  // the guard passes a sync chain, so eight cycles cover its delay
  property p_halt; (nrm && OVERVOLTAGE_GUARD) [*8] |-> !p; endproperty
  property p_run; (nrm && !OVERVOLTAGE_GUARD) [*8] |-> p; endproperty
  // the register may only move in a clock high phase, before the acknowledge
  property p_latch; $changed(c) |-> SCL_IN && SDA_OE_N; endproperty
  a_off: assert property (p_off) else $error("drive on");
  a_ind: assert property (p_ind) else $error("indicator");
  a_nrm: assert property (p_nrm) else $error("normal");
  a_cur: assert property (p_cur) else $error("current");
  a_ack: assert property (p_ack) else $error("ack");
  a_hold: assert property (p_hold) else $error("hold");
  a_halt: assert property (p_halt) else $error("halt");
  a_run: assert property (p_run) else $error("resume");
  a_latch: assert property (p_latch) else $error("latch");
endmodule : ldc_ctrl_properties

bind ldc_ctrl ldc_ctrl_properties ldc_ctrl_properties_inst (.*);

// ### ldc_host.sv
// Purpose: bus controller model
// Assumes: pull-up on the data wire
// Notes: 12 MCLK per bus phase
module ldc_host
(
  // clock
  input logic  MCLK,
  // bus
  input logic  SDA_W,
  output logic SCL,
  output logic SDA
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    SCL = 1'b1;
    SDA = 1'b1;
  end
  task automatic ph;
    repeat (12) @(posedge MCLK);
  endtask : ph
  // data moves mid low phase only, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    ph();
    SDA <= b;
    ph();
    SCL <= 1'b1;
    ph();
    s = SDA_W;
    SCL <= 1'b0;
  endtask : bit_io
  task automatic frame(input logic [31:0] d, input int n, output logic [3:0] a);
    logic s;
    a = 4'h0;
    ph();
    SDA <= 1'b0;
    ph();
    SCL <= 1'b0;
    for (int i = 0; i < 9 * n; i++)
    begin
      bit_io(i % 9 == 8 ? 1'b1 : d[31 - i + i / 9], s);
      if (i % 9 == 8)
        a[i / 9] = !s;
    end
    ph();
    SDA <= 1'b0;
    ph();
    SCL <= 1'b1;
    ph();
    SDA <= 1'b1;
  endtask : frame
endmodule : ldc_host

// ### testbench.sv
// Purpose: self-checking bench for ldc_ctrl
// Assumes: host model on the bus
// Notes: ack, register and drive checked together
module testbench;
  import ldc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, rst, overvoltage_guard, scl, sda_h, sda_o, oe_n;
  logic [7:0] ctl;
  wire ldc_drive_t drv;
  int         n_mismatch, n_checks;
  wire        sda_w = sda_h & (oe_n | sda_o);
  ldc_host ldc_host_inst (.MCLK(mclk), .SDA_W(sda_w), .SCL(scl), .SDA(sda_h));
  ldc_ctrl ldc_ctrl_inst (.MCLK(mclk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_w),
    .SDA_OUT(sda_o), .SDA_OE_N(oe_n), .OVERVOLTAGE_GUARD(overvoltage_guard), .PUMP_ON(drv.pump_on),
    .FIRST_CURRENT_SINK_ON(drv.sink1_on), .SECOND_CURRENT_SINK_ON(drv.sink2_on),
    .INDICATOR_MODE_SELECT(drv.indicator), .REFERENCE_CURRENT(drv.current),
    .LED_CURRENT_AND_MODE_CONTROL(ctl));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic ldc_drive_t exp_drv(input logic [7:0] r, input logic g);
    if (r == 8'h00)
      return '0;
    if (r[LDC_MODE_BIT])
      return '{1'b0, 1'b0, 1'b1, 1'b1, r[4:0]};
    return '{~g, 1'b1, 1'b1, 1'b0, r[4:0]};
  endfunction : exp_drv
  task automatic chk(input logic [20:0] e, input logic [20:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD ack_reg_drive expected %h seen %h", e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [31:0] d, int n, logic [3:0] ea, logic [7:0] er);
    logic [3:0] a;
    ldc_host_inst.frame(d, n, a);
    repeat (4) @(posedge mclk);
    #1;
    chk({ea, er, exp_drv(er, overvoltage_guard)}, {a, ctl, drv});
    chk({20'h0, 1'b1}, {20'h0, oe_n});
  endtask : wr
  initial
  begin
    rst = 1'b1;
    overvoltage_guard = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk(21'h0, {4'h0, ctl, drv});
    wr(32'h9e010a00, 3, 4'h7, 8'h0a);
    wr(32'h9e012500, 3, 4'h7, 8'h25);
    wr(32'h9e01c000, 3, 4'h7, 8'hc0);
    @(posedge mclk);
    overvoltage_guard <= 1'b1;
    wr(32'h9e011e00, 3, 4'h7, 8'h1e);
    @(posedge mclk);
    overvoltage_guard <= 1'b0;
    wr(32'h9c010500, 3, 4'h0, 8'h1e);
    wr(32'h9e020700, 3, 4'h7, 8'h1e);
    wr(32'h9e010303, 4, 4'h7, 8'h03);
    wr(32'h9e010000, 3, 4'h7, 8'h00);
    stop_test();
  end
endmodule : testbench
